/* refdac_host.sv */
// host-side model driving the three-wire serial link of the loader
`timescale 1ns/10ps

module refdac_host (
	input  wire logic mclk_i,
	output logic      sclk_o,
	output logic      load_select_n_o,
	output logic      serial_in_o
);
	// ==========================================================
	// idle link: clock low and still, select high
	initial begin
		sclk_o          = 1'b0;
		load_select_n_o = 1'b1;
		serial_in_o     = 1'b0;
	end
	// one link phase is five system cycles, an 80 ns shift period
	task automatic phase();
		repeat (5) @(posedge mclk_i);
	endtask
	// select falls only while the shift clock is already low
	task automatic open_frame();
		@(posedge mclk_i);
		sclk_o          <= 1'b0;
		load_select_n_o <= 1'b0;
		phase();
	endtask
	// top n bits of one word, msb first, data steady around each rising edge
	task automatic shift(input logic [15:0] w, input int n);
		for (int i = 15; i > 15 - n; i--) begin
			serial_in_o <= w[i];
			phase();
			sclk_o <= 1'b1;
			phase();
			sclk_o <= 1'b0;
		end
	endtask
	// select rises with the clock low; the released data line flips
	task automatic close_frame();
		phase();
		load_select_n_o <= 1'b1;
		serial_in_o     <= ~serial_in_o;
		phase();
		phase();
	endtask
	// faulty host: clock pulses while select is high, data toggling
	task automatic stray(input int n);
		for (int i = 0; i < n; i++) begin
			serial_in_o <= ~serial_in_o;
			phase();
			sclk_o <= 1'b1;
			phase();
			sclk_o <= 1'b0;
		end
	endtask
endmodule

/* refdac_loader.sv */
// serial command loader with channel holding registers, refresh clock and axi4-lite status port
//
// Contract
// - serial data accepted only while select low
// - sample input on each rising shift edge
// - msb first; first bit is bit 15
// - select rise after full word writes channel
// - shift clock gated while select high
// - buffered last stage out on falling edges
// - all chained devices update on select rise
// - bit 14 chooses internal or external clock
// - bits 13..10 hold binary channel address
// - ignore bit 13, decode lower three bits
// - bits 9..0 are the level code
// - refresh pin outputs or accepts clock
// - after reset internal source, pin undriven
// - internal source drives oscillator onto pin
// - refresh on falling, switches open rising
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps

module refdac_loader
	import refdac_pkg::*;
#(
	parameter int unsigned ADDR_W          = 8,
	parameter logic [15:0] OSC_HALF_DEFAULT = OSC_HALF_RESET
) (
	input  wire logic                         mclk_i,
	input  wire logic                         reset_i,
	// serial link pins
	input  wire logic                         sclk_i,
	input  wire logic                         load_select_n_i,
	input  wire logic                         serial_in_i,
	output logic                              serial_out_chain_o,
	// bidirectional refresh clock pin
	input  wire logic                         refresh_clock_pin_i,
	output logic                              refresh_clock_pin_o,
	output logic                              refresh_clock_pin_oe_o,
	// holding registers and refresh events toward the analog side
	output logic [NUM_CHAN*LEVEL_BITS-1:0]    level_codes_o,
	output logic                              refresh_strobe_o,
	output logic                              switch_open_o,
	// axi4-lite slave
	input  wire logic [ADDR_W-1:0]            s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [ADDR_W-1:0]            s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready
);
	// ==========================================================
	// pin synchronisation
	logic [3:0]            pins_s;            // {refresh pin, data, select, shift clock}
	logic                  sclk_s;            // synchronised shift clock
	logic                  lsn_s;             // synchronised select, active low
	logic                  sin_s;             // synchronised serial data
	logic                  pin_s;             // synchronised refresh pin
	logic                  sclk_d_reg;        // shift clock one cycle late
	logic                  lsn_d_reg;         // select one cycle late

	refdac_sync #(
		.WIDTH     (4),
		.RESET_VAL (SYNC_RESET)
	) u_sync (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.async_i ({refresh_clock_pin_i, serial_in_i, load_select_n_i, sclk_i}),
		.sync_o  (pins_s)
	);

	assign sclk_s = pins_s[0];
	assign lsn_s  = pins_s[1];
	assign sin_s  = pins_s[2];
	assign pin_s  = pins_s[3];

	// delayed copies for edge finding
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			sclk_d_reg <= 1'b0;
			lsn_d_reg  <= 1'b1;
		end else begin
			sclk_d_reg <= sclk_s;
			lsn_d_reg  <= lsn_s;
		end
	end

	// ==========================================================
	// edge decode, shift clock gated by select
	wire sclk_rise = sclk_s & ~sclk_d_reg & ~lsn_s;
	wire sclk_fall = ~sclk_s & sclk_d_reg & ~lsn_s;
	wire frame_end = lsn_s & ~lsn_d_reg;

	// ==========================================================
	// shift register and bit counter
	logic [WORD_BITS-1:0]  shreg_reg;         // incoming command word
	logic [4:0]            bit_cnt_reg;       // bits seen, saturates at a word
	logic                  sdo_reg;           // buffered last stage
	wire                   word_full = (bit_cnt_reg >= 5'(WORD_BITS));
	wire                   commit    = frame_end & word_full;
	wire                   short_end = frame_end & ~word_full;

	// shift in at the lsb so the first bit ends at bit 15
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			shreg_reg <= '0;
		end else if (sclk_rise) begin
			shreg_reg <= {shreg_reg[WORD_BITS-2:0], sin_s};
		end
	end

	// count bits per frame; cleared while select is high
	always_ff @(posedge mclk_i) begin
		if (reset_i || lsn_s) begin
			bit_cnt_reg <= '0;
		end else if (sclk_rise && !word_full) begin
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end

	// chain output follows the last stage on falling edges
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			sdo_reg <= 1'b0;
		end else if (sclk_fall) begin
			sdo_reg <= shreg_reg[WORD_BITS-1];
		end
	end
	assign serial_out_chain_o = sdo_reg;

	// ==========================================================
	// command decode; test bit and top address bit unused
	wire [ADDR_BITS-1:0]  cmd_addr  = shreg_reg[BIT_ADDR_HI:BIT_ADDR_LO];
	wire [LEVEL_BITS-1:0] cmd_level = shreg_reg[BIT_LVL_HI:BIT_LVL_LO];
	wire                  cmd_src   = shreg_reg[BIT_SRC];

	// ==========================================================
	// channel holding registers
	logic [LEVEL_BITS-1:0] level_mem [NUM_CHAN];  // one code per channel
	genvar c;
	generate
		for (c = 0; c < NUM_CHAN; c++) begin : g_chan
			wire hit = commit & (cmd_addr == ADDR_BITS'(c));
			// only the addressed channel loads
			always_ff @(posedge mclk_i) begin
				if (reset_i) begin
					level_mem[c] <= '0;
				end else if (hit) begin
					level_mem[c] <= cmd_level;
				end
			end
			assign level_codes_o[c*LEVEL_BITS +: LEVEL_BITS] = level_mem[c];
		end
	endgenerate

	// ==========================================================
	// clock source setting
	logic                  src_ext_reg;       // 1 selects the external pin
	logic                  programmed_reg;    // a full word has been taken
	// source only changes on a full frame
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			src_ext_reg    <= 1'b0;
			programmed_reg <= 1'b0;
		end else if (commit) begin
			src_ext_reg    <= cmd_src;
			programmed_reg <= 1'b1;
		end
	end

	// ==========================================================
	// internal oscillator
	logic [15:0]           osc_half_reg;      // half period in cycles, software set
	logic [15:0]           osc_cnt_reg;       // cycles into the half period
	logic                  osc_reg;           // oscillator level
	wire                   osc_wrap = ((17'(osc_cnt_reg) + 17'h00001) >= 17'(osc_half_reg));
	// free running divider
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			osc_cnt_reg <= '0;
			osc_reg     <= 1'b0;
		end else if (osc_wrap) begin
			osc_cnt_reg <= '0;
			osc_reg     <= ~osc_reg;
		end else begin
			osc_cnt_reg <= osc_cnt_reg + 16'h0001;
		end
	end

	// ==========================================================
	// refresh pin drive and refresh events
	wire  pin_drive  = programmed_reg & ~src_ext_reg;
	wire  sel_clk    = src_ext_reg ? pin_s : osc_reg;
	logic pin_out_reg;                                 // pin level
	logic pin_oe_reg;                                  // pin enable
	logic sel_d_reg;                                   // selected clock one cycle late
	logic strobe_reg;                                  // refresh pulse
	logic sw_open_reg;                                 // switch open pulse
	// pin and refresh event registers
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			pin_out_reg <= 1'b0;
			pin_oe_reg  <= 1'b0;
			sel_d_reg   <= 1'b0;
			strobe_reg  <= 1'b0;
			sw_open_reg <= 1'b0;
		end else begin
			pin_out_reg <= osc_reg;
			pin_oe_reg  <= pin_drive;
			sel_d_reg   <= sel_clk;
			strobe_reg  <= ~sel_clk & sel_d_reg;
			sw_open_reg <= sel_clk & ~sel_d_reg;
		end
	end
	assign refresh_clock_pin_o    = pin_out_reg;
	assign refresh_clock_pin_oe_o = pin_oe_reg;
	assign refresh_strobe_o       = strobe_reg;
	assign switch_open_o          = sw_open_reg;

	// ==========================================================
	// axi4-lite write path
	logic                  awready_reg;       // address channel free
	logic                  wready_reg;        // data channel free
	logic                  bvalid_reg;        // response pending
	logic [1:0]            bresp_reg;         // response code
	logic [ADDR_W-1:0]     waddr_reg;         // held write address
	logic [31:0]           wdata_reg;         // held write data
	logic [3:0]            wstrb_reg;         // held byte enables
	logic                  short_reg;         // sticky short frame flag
	logic [7:0]            frame_cnt_reg;     // committed frames, wraps
	wire aw_hs   = s_axi_awvalid & awready_reg;
	wire w_hs    = s_axi_wvalid & wready_reg;
	wire do_wr   = ~awready_reg & ~wready_reg & ~bvalid_reg;
	wire wr_half = do_wr & (waddr_reg[7:2] == OFS_OSC_HALF[7:2]);
	wire wr_stat = do_wr & (waddr_reg[7:2] == OFS_STATUS[7:2]);
	wire wr_chan = do_wr & (waddr_reg[7:0] >= OFS_CHAN_BASE) & (waddr_reg[7:0] <= OFS_CHAN_LAST);
	wire wr_ok   = wr_half | wr_stat | wr_chan;
	wire clr_short = wr_stat & wstrb_reg[0] & wdata_reg[STAT_SHORT];
	wire [15:0] half_next = {wstrb_reg[1] ? wdata_reg[15:8] : osc_half_reg[15:8],
	                         wstrb_reg[0] ? wdata_reg[7:0] : osc_half_reg[7:0]};

	// take address and data in either order, answer once both held
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			waddr_reg   <= '0;
			wdata_reg   <= '0;
			wstrb_reg   <= '0;
		end else begin
			if (aw_hs) begin
				awready_reg <= 1'b0;
				waddr_reg   <= s_axi_awaddr;
			end
			if (w_hs) begin
				wready_reg <= 1'b0;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (do_wr) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_reg && s_axi_bready) begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// software registers; a new short frame beats the clear
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			osc_half_reg  <= OSC_HALF_DEFAULT;
			short_reg     <= 1'b0;
			frame_cnt_reg <= '0;
		end else begin
			if (wr_half) begin
				osc_half_reg <= half_next;
			end
			if (short_end) begin
				short_reg <= 1'b1;
			end else if (clr_short) begin
				short_reg <= 1'b0;
			end
			if (commit) begin
				frame_cnt_reg <= frame_cnt_reg + 8'h01;
			end
		end
	end
	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;

	// ==========================================================
	// axi4-lite read path
	logic                  arready_reg;       // address channel free
	logic                  rvalid_reg;        // data pending
	logic [31:0]           rdata_reg;         // read data
	logic [1:0]            rresp_reg;         // read response
	wire [7:0]  raddr   = 8'(s_axi_araddr);
	wire        rd_half = (raddr[7:2] == OFS_OSC_HALF[7:2]);
	wire        rd_stat = (raddr[7:2] == OFS_STATUS[7:2]);
	wire        rd_chan = (raddr >= OFS_CHAN_BASE) & (raddr <= OFS_CHAN_LAST);
	wire [2:0]  rd_idx  = raddr[4:2];
	wire [31:0] stat_word = {16'h0000, frame_cnt_reg, 5'h00, short_reg, pin_oe_reg, src_ext_reg};
	wire [31:0] rd_mux  = rd_half ? {16'h0000, osc_half_reg} :
	                      rd_stat ? stat_word :
	                      rd_chan ? {22'h000000, level_mem[rd_idx]} : 32'h00000000;
	wire        ar_hs   = s_axi_arvalid & arready_reg;

	// one read at a time, answer the cycle after the address is taken
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= '0;
			rresp_reg   <= RESP_OKAY;
		end else if (ar_hs) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= rd_mux;
			rresp_reg   <= (rd_half | rd_stat | rd_chan) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg  <= 1'b0;
			arready_reg <= 1'b1;
		end
	end
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// ==========================================================
	// assertions
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	a_gated_shift_idle: assert property (lsn_s |=> $stable(shreg_reg))
		else $error("shift register moved while select high");
	a_shift_msb_first: assert property (sclk_rise |=> (shreg_reg[0] == $past(sin_s)) &&
		(shreg_reg[15:1] == $past(shreg_reg[14:0])))
		else $error("serial bit not shifted in at lsb");
	a_commit_channel: assert property (commit |=>
		level_mem[$past(shreg_reg[12:10])] == $past(shreg_reg[9:0]))
		else $error("addressed channel not loaded");
	a_short_frame_keep: assert property (short_end |=> $stable(level_codes_o) && $stable(src_ext_reg))
		else $error("short frame changed state");
	a_source_bit: assert property (commit |=> src_ext_reg == $past(shreg_reg[14]))
		else $error("clock source not taken from bit 14");
	a_chain_out_fall: assert property (sclk_fall |=> serial_out_chain_o == $past(shreg_reg[15]))
		else $error("chain output not last stage");
	a_pin_hiz_reset: assert property (!programmed_reg |=> !refresh_clock_pin_oe_o)
		else $error("refresh pin driven before programming");
	a_osc_drive_out: assert property (pin_drive |=> refresh_clock_pin_oe_o && refresh_clock_pin_o == $past(osc_reg))
		else $error("internal source not driven onto pin");
	a_refresh_edges: assert property ((~sel_clk & sel_d_reg) |=> refresh_strobe_o && !switch_open_o)
		else $error("refresh strobe missing on falling edge");
	a_one_channel: assert property (commit |=>
		((level_codes_o ^ $past(level_codes_o)) & ~({70'h0, 10'h3FF} << (LEVEL_BITS * $past(shreg_reg[12:10])))) == '0
		&& $stable(frame_cnt_reg) == 1'b0)
		else $error("more than one channel changed");
endmodule

/* refdac_loader_tb.sv */
// self-checking bench for the serial loader and its status port
`timescale 1ns/10ps

module refdac_loader_tb;
	import refdac_pkg::*;
	localparam logic [15:0] HALF = 16'h0004;  // shortened oscillator half period
	// ==========================================================
	// signals
	logic        mclk_i = 1'b0;                // system clock
	logic        reset_i = 1'b1;               // synchronous reset
	logic        sclk, sel_n, serial_in, sout;       // serial link
	logic        pin_o, pin_oe, strobe, sw_open;
	logic        ext_drv = 1'b0;               // far-side refresh clock driver
	wire         pin_wire = pin_oe ? pin_o : ext_drv;  // resolved refresh pin level
	logic [79:0] levels;                       // holding registers
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [9:0]  model [8] = '{default: 10'h000};  // expected channel codes
	logic        obs [0:511];                  // chain output after each falling edge
	logic [33:0] exp_q [$];                    // expected read responses
	string       nm_q [$];
	int          err_total = 0, samples_checked = 0, n_str = 0, n_sw = 0, nfall = 0;
	int          n_pin = 0;                    // rising edges seen on the driven refresh pin
	logic        pin_d = 1'b0;                 // refresh pin one cycle late
	logic [15:0] wa, wb, prev;
	logic [9:0]  lv;
	logic [47:0] s;
	// 125 MHz system clock
	always #4 mclk_i = ~mclk_i;
	// ==========================================================
	// design and far-side host
	refdac_loader #(.ADDR_W(8), .OSC_HALF_DEFAULT(HALF)) u_refdac_loader (
		.mclk_i(mclk_i), .reset_i(reset_i), .sclk_i(sclk), .load_select_n_i(sel_n),
		.serial_in_i(serial_in), .serial_out_chain_o(sout), .refresh_clock_pin_i(pin_wire),
		.refresh_clock_pin_o(pin_o), .refresh_clock_pin_oe_o(pin_oe), .level_codes_o(levels),
		.refresh_strobe_o(strobe), .switch_open_o(sw_open), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	refdac_host u_refdac_host (.mclk_i(mclk_i), .sclk_o(sclk), .load_select_n_o(sel_n), .serial_in_o(serial_in));
	// ==========================================================
	// comparison, verdict and helpers
	task automatic check(input string nm, input logic [79:0] seen, input logic [79:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results();
		if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [79:0] flat();
		logic [79:0] f;
		for (int c = 0; c < 8; c++) f[c*10 +: 10] = model[c];
		return f;
	endfunction
	// one full 16-bit frame, then the expected channel is updated
	task automatic frame(input logic [15:0] w);
		u_refdac_host.open_frame();
		u_refdac_host.shift(w, 16);
		u_refdac_host.close_frame();
		model[w[12:10]] = w[9:0];
	endtask
	// axi4-lite write, address and data offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, da, dw;
		da = 1'b0;
		dw = 1'b0;
		@(posedge mclk_i);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (!(da && dw)) begin
			@(negedge mclk_i);
			ta = s_axi_awready;
			tw = s_axi_wready;
			@(posedge mclk_i);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			da = da | ta;
			dw = dw | tw;
		end
		do begin
			@(negedge mclk_i);
			ta = s_axi_bvalid;
			@(posedge mclk_i);
		end while (!ta);
		s_axi_bready <= 1'b0;
		check("write response", s_axi_bresp, er);
	endtask
	// axi4-lite read; the observer compares the response
	task automatic axi_rd(input logic [7:0] a, input logic [33:0] e, input string nm);
		logic t;
		exp_q.push_back(e);
		nm_q.push_back(nm);
		@(posedge mclk_i);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(negedge mclk_i);
			t = s_axi_arready;
			@(posedge mclk_i);
		end while (!t);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge mclk_i);
			t = s_axi_rvalid;
			@(posedge mclk_i);
		end while (!t);
		s_axi_rready <= 1'b0;
	endtask
	// ==========================================================
	// observers: read responses, refresh pulses, chain output
	always @(posedge mclk_i) begin
		if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) check(nm_q.pop_front(), {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		if (strobe) n_str++;
		if (sw_open) n_sw++;
		if (pin_oe && pin_wire && !pin_d) n_pin++;
		pin_d <= pin_wire;
	end
	always @(negedge sclk) begin
		repeat (7) @(posedge mclk_i);
		obs[nfall] = sout;
		nfall++;
	end
	// watchdog cuts a hang short
	initial begin
		repeat (30000) @(posedge mclk_i);
		err_total++;
		results();
	end
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(96));
		repeat (3) @(posedge mclk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		check("pin enable after reset", pin_oe, 1'b0);
		check("levels after reset", levels, flat());
		axi_rd(OFS_OSC_HALF, {RESP_OKAY, 16'h0, HALF}, "half period");
		axi_wr(OFS_OSC_HALF, {16'hFFFF, 16'h0005}, RESP_OKAY);
		axi_rd(OFS_OSC_HALF, {RESP_OKAY, 16'h0, 16'h0005}, "half period");
		axi_wr(OFS_OSC_HALF, {16'h0000, HALF}, RESP_OKAY);
		axi_wr(8'h10, 32'h0, RESP_SLVERR);
		axi_rd(8'h10, {RESP_SLVERR, 32'h0}, "unmapped");
		for (int c = 0; c < 8; c++) begin
			lv = 10'($urandom);
			frame({3'b000, 3'(c), lv});
			check("levels", levels, flat());
			axi_rd(OFS_CHAN_BASE + 8'(4 * c), {RESP_OKAY, 22'h0, lv}, "channel word");
		end
		check("pin enable internal", pin_oe, 1'b1);
		n_str = 0;
		n_pin = 0;
		repeat (64) @(posedge mclk_i);
		check("internal refresh strobes", n_str inside {[6:9]}, 1'b1);
		check("refresh pin edges", n_pin inside {[6:9]}, 1'b1);
		prev = {3'b001, 3'd5, 10'($urandom)};
		frame(prev);
		check("top address bit ignored", levels, flat());
		u_refdac_host.stray(4);
		repeat (10) @(posedge mclk_i);
		wa = {3'b000, 3'($urandom), 10'($urandom)};
		wb = {3'b000, 3'($urandom), 10'($urandom)};
		s = {prev, wa, wb};
		nfall = 1;
		u_refdac_host.open_frame();
		u_refdac_host.shift(wa, 16);
		frame(wb);
		for (int k = 1; k <= 32; k++) check("chain out", obs[k], s[47-k]);
		check("chained word", levels, flat());
		frame({3'b010, 3'd0, 10'($urandom)});
		check("pin enable external", pin_oe, 1'b0);
		n_str = 0;
		n_sw = 0;
		for (int i = 0; i < 10; i++) begin
			repeat (8) @(posedge mclk_i);
			ext_drv <= 1'b1;
			repeat (8) @(posedge mclk_i);
			ext_drv <= 1'b0;
		end
		repeat (8) @(posedge mclk_i);
		check("external strobes", n_str, 10);
		check("external switch opens", n_sw, 10);
		u_refdac_host.open_frame();
		u_refdac_host.shift({3'b000, 3'd1, 10'h3FF}, 8);
		u_refdac_host.close_frame();
		check("short frame levels", levels, flat());
		check("short frame source", pin_oe, 1'b0);
		axi_rd(OFS_STATUS, {RESP_OKAY, 16'h0, 8'h0B, 8'h05}, "status short");
		axi_wr(OFS_STATUS, 32'h00000004, RESP_OKAY);
		axi_rd(OFS_STATUS, {RESP_OKAY, 16'h0, 8'h0B, 8'h01}, "status cleared");
		repeat (2) @(posedge mclk_i);
		results();
	end
endmodule

/* refdac_sync.sv */
// package of shared constants and the two-flop input synchroniser
`timescale 1ns/10ps
package refdac_pkg;
	// ==========================================================
	// clock and timing
	localparam int unsigned CLK_HZ       = 125_000_000;  // system clock rate
	localparam int unsigned OSC_FREQ_HZ  = 25_000;       // internal refresh oscillator rate
	localparam int unsigned OSC_HALF_CYC = CLK_HZ / (2 * OSC_FREQ_HZ);  // cycles per half period
	// ==========================================================
	// command word layout
	localparam int unsigned WORD_BITS    = 16;           // bits per command word
	localparam int unsigned LEVEL_BITS   = 10;           // level code width
	localparam int unsigned NUM_CHAN     = 8;            // holding registers
	localparam int unsigned ADDR_BITS    = 3;            // decoded channel address bits
	localparam int unsigned BIT_TEST     = 15;           // reserved test bit
	localparam int unsigned BIT_SRC      = 14;           // clock source select
	localparam int unsigned BIT_ADDR_TOP = 13;           // ignored address bit
	localparam int unsigned BIT_ADDR_HI  = 12;           // decoded address msb
	localparam int unsigned BIT_ADDR_LO  = 10;           // decoded address lsb
	localparam int unsigned BIT_LVL_HI   = 9;            // level code msb
	localparam int unsigned BIT_LVL_LO   = 0;            // level code lsb
	// ==========================================================
	// software register map (byte offsets)
	localparam logic [7:0] OFS_OSC_HALF  = 8'h00;        // oscillator half period, rw
	localparam logic [7:0] OFS_STATUS    = 8'h04;        // status, ro with one w1c bit
	localparam logic [7:0] OFS_CHAN_BASE = 8'h20;        // first channel readback word
	localparam logic [7:0] OFS_CHAN_LAST = 8'h3C;        // last channel readback word
	localparam int unsigned STAT_SRC     = 0;            // selected clock source
	localparam int unsigned STAT_DRIVE   = 1;            // refresh pin driven
	localparam int unsigned STAT_SHORT   = 2;            // short frame seen, sticky
	localparam int unsigned STAT_CNT_LO  = 8;            // frame counter lsb
	localparam logic [15:0] OSC_HALF_RESET = 16'(OSC_HALF_CYC);  // half period after reset
	localparam logic [1:0]  RESP_OKAY    = 2'h0;         // axi okay
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;         // axi slave error
	localparam logic [3:0]  SYNC_RESET   = 4'h2;         // pin, data, select, clock after reset
endpackage

// two flip-flops per bit for inputs arriving from outside the clock domain
module refdac_sync #(
	parameter int unsigned      WIDTH     = 4,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             mclk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	// ==========================================================
	// per-bit synchroniser chain
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic meta_reg;  // first stage, read only by the second
			logic sync_reg;  // second stage
			// stage registers, reset to the idle level of the line
			always_ff @(posedge mclk_i) begin
				if (reset_i) begin
					meta_reg <= RESET_VAL[g];
					sync_reg <= RESET_VAL[g];
				end else begin
					meta_reg <= async_i[g];
					sync_reg <= meta_reg;
				end
			end
			assign sync_o[g] = sync_reg;
		end
	endgenerate
endmodule
